// ### hdl/mdu_unit.sv
// multiply/divide unit beside the integer pipeline
`timescale 1ns/1ps
`default_nettype none
module mdu_unit
  import mdu_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // issue from the integer pipeline
  input wire logic issue_valid,
  input wire mdu_issue_t issue_cmd,
  output logic issue_stall,
  // results
  output logic [`MDU_WORD_W-1:0] acc_top_word,
  output logic [`MDU_WORD_W-1:0] acc_bottom_word,
  output logic gpr_valid,
  output logic [`MDU_WORD_W-1:0] gpr_data,
  output logic div_busy
);

  // ****************************************
  // decode helpers
  // ****************************************
  // true when bits n and up are copies of bit n-1 when signed, or all zero when unsigned
  function automatic logic ext_fits(input mdu_word_t v, input logic sgn,
                                    input int unsigned n);
    mdu_word_t mask;
    logic fill;
    mask = '1;
    mask = mask << n;
    fill = sgn & v[n-1];
    ext_fits = ((v & mask) == (fill ? mask : '0));
  endfunction

  logic accept;
  logic is_mul;
  logic b_short;
  mdu_issue_t mcmd;
  mdu_word_t a_in;
  mdu_word_t b_in;
  logic sgn;

  assign a_in = issue_cmd.source_a_operand;
  assign b_in = issue_cmd.source_b_operand;
  assign sgn = issue_cmd.is_signed;
  assign accept = issue_valid & ~issue_stall;
  assign is_mul = issue_cmd.op inside {product_to_acc_op, acc_plus_product_op,
                                       acc_minus_product_op, product_to_gpr_op};
  assign b_short = ext_fits(b_in, sgn, `MDU_HALF_W);

  // ****************************************
  // state declarations
  // ****************************************
  mdu_mul_state_t mul_state_reg, mul_state_next;
  mdu_issue_t hold_reg, hold_next;
  logic [63:0] part_reg, part_next;
  logic [63:0] acc_reg, acc_next;
  logic stage_valid_reg, stage_valid_next;
  mdu_word_t stage_data_reg, stage_data_next;
  logic gpr_valid_reg, gpr_valid_next;
  mdu_word_t gpr_data_reg, gpr_data_next;
  mdu_div_state_t div_state_reg, div_state_next;
  logic [5:0] div_cnt_reg, div_cnt_next;
  logic [5:0] div_iter_reg, div_iter_next;
  mdu_word_t rem_reg, rem_next;
  mdu_word_t quo_reg, quo_next;
  mdu_word_t dvs_reg, dvs_next;
  logic neg_q_reg, neg_q_next;
  logic neg_r_reg, neg_r_next;

  // ****************************************
  // 32x16 multiplier array
  // ****************************************
  logic signed [32:0] m_a;
  logic signed [16:0] m_b;
  logic signed [49:0] m_prod;
  logic [63:0] prod64;
  logic [63:0] mul_final;
  logic pass2;
  logic mul_done;

  assign pass2 = (mul_state_reg == MUL_PASS2);
  assign mcmd = pass2 ? hold_reg : issue_cmd;

  always_comb begin
    // operands widened by one bit so unsigned values stay positive
    m_a = {mcmd.is_signed & mcmd.source_a_operand[31],
           mcmd.source_a_operand};
    if (pass2) begin
      m_b = {mcmd.is_signed & mcmd.source_b_operand[31],
             mcmd.source_b_operand[31:16]};
    end else if (b_short) begin
      m_b = {sgn & b_in[15], b_in[15:0]};
    end else begin
      m_b = {1'b0, b_in[15:0]};
    end
    m_prod = m_a * m_b;
    prod64 = {{14{m_prod[49]}}, m_prod};
    mul_final = pass2 ? (part_reg + {prod64[47:0], 16'h0000}) : prod64;
  end

  // a product is complete after one pass when b is short, else two
  assign mul_done = pass2 | (accept & is_mul & b_short);

  // ****************************************
  // issue interlocks
  // ****************************************
  logic div_last;
  logic div_block;
  logic move_op;

  assign div_busy = (div_state_reg != DIV_IDLE);
  assign div_last = (div_state_reg == DIV_ITER) && (div_cnt_reg == 6'h01);
  assign move_op = issue_cmd.op inside {move_from_top_op, move_from_bottom_op};
  // a divide may follow a divide in its final cycle, nothing else may
  assign div_block = div_busy &
                     ~(div_last & (issue_cmd.op == quotient_op));
  // second pass holds the array, so every issue waits one cycle
  assign issue_stall = issue_valid & (pass2 | div_block |
                       (move_op & stage_valid_reg));

  // ****************************************
  // multiply and accumulator control
  // ****************************************
  logic [5:0] skip;
  logic [5:0] lat;
  logic [5:0] iter;
  mdu_word_t mag_a;
  mdu_word_t mag_b;
  logic [33:0] trial;
  mdu_word_t q_step;
  mdu_word_t r_step;

  always_comb begin
    mul_state_next = MUL_PASS1;
    hold_next = hold_reg;
    part_next = part_reg;
    acc_next = acc_reg;
    stage_valid_next = 1'b0;
    stage_data_next = stage_data_reg;
    gpr_valid_next = 1'b0;
    gpr_data_next = gpr_data_reg;
    if (accept && is_mul && !b_short) begin
      mul_state_next = MUL_PASS2;
      hold_next = issue_cmd;
      part_next = prod64;
    end
    if (mul_done) begin
      unique case (mcmd.op)
        acc_plus_product_op: acc_next = acc_reg + mul_final;
        acc_minus_product_op: acc_next = acc_reg - mul_final;
        product_to_gpr_op: begin
          // the extra stage gives latency 2 or 3
          stage_valid_next = 1'b1;
          stage_data_next = mul_final[31:0];
        end
        default: acc_next = mul_final;
      endcase
    end
    if (div_last) begin
      acc_next = {neg_r_reg ? -r_step : r_step,
                  neg_q_reg ? -q_step : q_step};
    end
    if (stage_valid_reg) begin
      gpr_valid_next = 1'b1;
      gpr_data_next = stage_data_reg;
    end else if (accept && move_op) begin
      gpr_valid_next = 1'b1;
      gpr_data_next = (issue_cmd.op == move_from_top_op) ?
                      acc_reg[63:32] : acc_reg[31:0];
    end
  end

  // ****************************************
  // iterative divider
  // ****************************************
  always_comb begin
    // magnitudes; signs are put back when the result is written
    mag_a = (sgn & a_in[31]) ? -a_in : a_in;
    mag_b = (sgn & b_in[31]) ? -b_in : b_in;
    if (ext_fits(a_in, sgn, 8)) begin
      skip = `MDU_SKIP_8;
      lat = `MDU_DIV_LAT_8;
    end else if (ext_fits(a_in, sgn, 16)) begin
      skip = `MDU_SKIP_16;
      lat = `MDU_DIV_LAT_16;
    end else if (ext_fits(a_in, sgn, 24)) begin
      skip = `MDU_SKIP_24;
      lat = `MDU_DIV_LAT_24;
    end else begin
      skip = `MDU_SKIP_32;
      lat = `MDU_DIV_LAT_32;
    end
    iter = 6'h20 - skip;
    // one restoring step: one quotient bit
    trial = {1'b0, rem_reg, quo_reg[31]} - {2'h0, dvs_reg};
    r_step = trial[33] ? {rem_reg[30:0], quo_reg[31]} : trial[31:0];
    q_step = {quo_reg[30:0], ~trial[33]};
    div_state_next = div_state_reg;
    div_cnt_next = div_cnt_reg;
    div_iter_next = div_iter_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    dvs_next = dvs_reg;
    neg_q_next = neg_q_reg;
    neg_r_next = neg_r_reg;
    unique case (div_state_reg)
      DIV_PAD: begin
        div_cnt_next = div_cnt_reg - 6'h01;
        if (div_cnt_reg == 6'h01) begin
          div_state_next = DIV_ITER;
          div_cnt_next = div_iter_reg;
        end
      end
      DIV_ITER: begin
        rem_next = r_step;
        quo_next = q_step;
        div_cnt_next = div_cnt_reg - 6'h01;
        if (div_last) begin
          div_state_next = DIV_IDLE;
        end
      end
      default: ;
    endcase
    if (accept && issue_cmd.op == quotient_op) begin
      // padding makes the overall latency match the size class
      div_iter_next = iter;
      rem_next = '0;
      quo_next = mag_a << skip;
      dvs_next = mag_b;
      neg_q_next = sgn & (a_in[31] ^ b_in[31]);
      neg_r_next = sgn & a_in[31];
      if (lat - 6'h01 == iter) begin
        div_state_next = DIV_ITER;
        div_cnt_next = iter;
      end else begin
        div_state_next = DIV_PAD;
        div_cnt_next = lat - 6'h01 - iter;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // no stall input: work in flight moves on while the pipeline waits
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mul_state_reg <= MUL_PASS1;
      hold_reg <= '0;
      part_reg <= '0;
      acc_reg <= {`MDU_ACC_RST, `MDU_ACC_RST};
      stage_valid_reg <= 1'b0;
      stage_data_reg <= '0;
      gpr_valid_reg <= 1'b0;
      gpr_data_reg <= '0;
      div_state_reg <= DIV_IDLE;
      div_cnt_reg <= 6'h00;
      div_iter_reg <= 6'h00;
      rem_reg <= '0;
      quo_reg <= '0;
      dvs_reg <= '0;
      neg_q_reg <= 1'b0;
      neg_r_reg <= 1'b0;
    end else begin
      mul_state_reg <= mul_state_next;
      hold_reg <= hold_next;
      part_reg <= part_next;
      acc_reg <= acc_next;
      stage_valid_reg <= stage_valid_next;
      stage_data_reg <= stage_data_next;
      gpr_valid_reg <= gpr_valid_next;
      gpr_data_reg <= gpr_data_next;
      div_state_reg <= div_state_next;
      div_cnt_reg <= div_cnt_next;
      div_iter_reg <= div_iter_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      dvs_reg <= dvs_next;
      neg_q_reg <= neg_q_next;
      neg_r_reg <= neg_r_next;
    end
  end

  assign acc_top_word = acc_reg[63:32];
  assign acc_bottom_word = acc_reg[31:0];
  assign gpr_valid = gpr_valid_reg;
  assign gpr_data = gpr_data_reg;

  // ****************************************
  // assertions
  // ****************************************
  mul_back_stall_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && is_mul && !b_short |=> (issue_valid |-> issue_stall))
    else $error("32x32 multiply not interlocked");
  short_issue_a: assert property (@(posedge clock) disable iff (sys_rst)
    issue_valid && is_mul && b_short && !pass2 && !div_busy |-> !issue_stall)
    else $error("short multiply stalled");
  acc_short_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && issue_cmd.op == product_to_acc_op && b_short
    |=> {acc_top_word, acc_bottom_word} == $past(prod64))
    else $error("short multiply result late or wrong");
  madd_sum_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && issue_cmd.op == acc_plus_product_op && b_short
    |=> acc_reg == $past(acc_reg) + $past(prod64))
    else $error("accumulate-add result wrong");
  gpr_short_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && issue_cmd.op == product_to_gpr_op && b_short
    |-> ##1 stage_valid_reg ##1 gpr_valid)
    else $error("multiply-to-register latency not 2");
  gpr_long_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && issue_cmd.op == product_to_gpr_op && !b_short
    |-> ##2 !gpr_valid ##1 gpr_valid)
    else $error("multiply-to-register latency not 3");
  div_stall_a: assert property (@(posedge clock) disable iff (sys_rst)
    div_busy && issue_valid && issue_cmd.op != quotient_op |-> issue_stall)
    else $error("issue taken during divide");
  div_byte_a: assert property (@(posedge clock) disable iff (sys_rst)
    accept && issue_cmd.op == quotient_op && ext_fits(a_in, sgn, 8)
    |-> ##1 div_busy ##10 div_last)
    else $error("8-bit divide latency not 12");
  div_step_a: assert property (@(posedge clock) disable iff (sys_rst)
    div_state_reg == DIV_ITER && div_cnt_reg > 6'h01
    |=> div_state_reg == DIV_ITER && div_cnt_reg == $past(div_cnt_reg) - 6'h01)
    else $error("divide step skipped");

endmodule
`default_nettype wire

// ### hdl/mdu_consts.svh
// constants of the multiply/divide unit
`ifndef MDU_CONSTS_SVH
`define MDU_CONSTS_SVH
`define MDU_WORD_W 32
`define MDU_HALF_W 16
`define MDU_SKIP_8 6'h17
`define MDU_SKIP_16 6'h0F
`define MDU_SKIP_24 6'h07
`define MDU_SKIP_32 6'h00
`define MDU_DIV_LAT_8 6'h0C
`define MDU_DIV_LAT_16 6'h13
`define MDU_DIV_LAT_24 6'h1A
`define MDU_DIV_LAT_32 6'h21
`define MDU_ACC_RST 32'h00000000
`endif

// ### hdl/mdu_pkg.sv
// types of the multiply/divide unit
`include "mdu_consts.svh"
package mdu_pkg;
  typedef logic [`MDU_WORD_W-1:0] mdu_word_t;
  typedef enum logic [2:0] {
    product_to_acc_op = 3'h0,
    acc_plus_product_op = 3'h1,
    acc_minus_product_op = 3'h2,
    product_to_gpr_op = 3'h3,
    quotient_op = 3'h4,
    move_from_top_op = 3'h5,
    move_from_bottom_op = 3'h6
  } mdu_op_t;
  typedef struct packed {
    mdu_op_t op;
    logic is_signed;
    mdu_word_t source_a_operand;
    mdu_word_t source_b_operand;
  } mdu_issue_t;
  typedef enum logic [1:0] {
    DIV_IDLE = 2'h0,
    DIV_PAD = 2'h1,
    DIV_ITER = 2'h3
  } mdu_div_state_t;
  typedef enum logic {
    MUL_PASS1 = 1'h0,
    MUL_PASS2 = 1'h1
  } mdu_mul_state_t;
endpackage

// ### dv/mdu_pipe_model.sv
// model of the integer pipeline that issues work to the unit
`timescale 1ns/1ps
`default_nettype none
module mdu_pipe_model
  import mdu_pkg::*;
(
  // clock
  input wire logic clock,
  // issue towards the unit
  output logic issue_valid,
  output mdu_issue_t issue_cmd,
  input wire logic issue_stall
);
  // ****************************************
  // issue driver
  // ****************************************
  initial begin
    issue_valid = 1'b0;
    issue_cmd = '0;
  end
  // set after a falling edge, held until a rising edge sees no stall;
  // keep leaves the request up so a further issue follows back to back
  task automatic issue(input mdu_issue_t c, input bit keep,
                       output int stalls);
    stalls = 0;
    @(negedge clock);
    issue_valid = 1'b1;
    issue_cmd = c;
    #1;
    while (issue_stall !== 1'b0) begin
      stalls++;
      @(negedge clock);
      #1;
    end
    @(posedge clock);
    if (!keep) begin
      @(negedge clock);
      issue_valid = 1'b0;
      // released lines show no stale value
      issue_cmd = ~c;
    end
  endtask
endmodule
`default_nettype wire

// ### dv/mdu_unit_tb.sv
// self-checking testbench of the multiply/divide unit
`timescale 1ns/1ps
`default_nettype none
module mdu_unit_tb
  import mdu_pkg::*;
;
  logic clock, sys_rst, issue_valid, issue_stall, gpr_valid, div_busy;
  mdu_issue_t issue_cmd;
  logic [31:0] acc_top_word, acc_bottom_word, gpr_data;
  logic [63:0] acc_exp;
  int err_total, checks, st;
  // ****************************************
  // harness
  // ****************************************
  initial clock = 1'b0;
  always #2.5 clock = ~clock;
  mdu_unit DUT (.clock(clock), .sys_rst(sys_rst),
    .issue_valid(issue_valid), .issue_cmd(issue_cmd),
    .issue_stall(issue_stall), .acc_top_word(acc_top_word),
    .acc_bottom_word(acc_bottom_word), .gpr_valid(gpr_valid),
    .gpr_data(gpr_data), .div_busy(div_busy));
  mdu_pipe_model pipe (.clock(clock), .issue_valid(issue_valid),
    .issue_cmd(issue_cmd), .issue_stall(issue_stall));
  task automatic chk(input string name, input logic [63:0] seen,
                     input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic mdu_issue_t cmd(mdu_op_t op, logic s,
                                     logic [31:0] a, logic [31:0] b);
    cmd = '{op, s, a, b};
  endfunction
  function automatic logic [63:0] prod(logic s, logic [31:0] a,
                                       logic [31:0] b);
    logic [63:0] xa, xb;
    xa = {{32{s & a[31]}}, a};
    xb = {{32{s & b[31]}}, b};
    prod = xa * xb;
  endfunction
  function automatic logic [63:0] acc();
    acc = {acc_top_word, acc_bottom_word};
  endfunction
  // ****************************************
  // helpers, entered at cycle 1 after an accept
  // ****************************************
  task automatic acc_at(input int n, input logic [63:0] exp);
    if (n > 1) begin
      repeat (n - 2) @(negedge clock);
      chk("acc early", acc(), acc_exp);
      @(negedge clock);
    end
    chk("acc", acc(), exp);
    acc_exp = exp;
  endtask
  task automatic gpr_at(input int n, input logic [31:0] exp);
    repeat (n - 2) @(negedge clock);
    chk("gpr early", gpr_valid, 1'b0);
    @(negedge clock);
    chk("gpr valid", gpr_valid, 1'b1);
    chk("gpr data", gpr_data, exp);
    @(negedge clock);
    chk("gpr drop", gpr_valid, 1'b0);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk("acc reset", acc(), 64'h0);
    chk("flags reset", {gpr_valid, div_busy, issue_stall}, 3'h0);
    chk("gpr reset", gpr_data, 32'h0);
  endtask
  task automatic t_short();
    logic [31:0] a, b;
    a = 32'hFFFFFFF0;
    b = 32'h00007FF3;
    for (int s = 0; s < 2; s++) begin
      pipe.issue(cmd(product_to_acc_op, s[0], a, b), 1'b0, st);
      acc_at(1, prod(s[0], a, b));
    end
    pipe.issue(cmd(product_to_acc_op, 1'b1, b, 32'hFFFF8000), 1'b1, st);
    pipe.issue(cmd(product_to_acc_op, 1'b1, a, 32'hFFFFFFFE), 1'b0, st);
    chk("back to back", st, 0);
    acc_at(1, prod(1'b1, a, 32'hFFFFFFFE));
  endtask
  task automatic t_long();
    logic [31:0] a, b, c;
    a = 32'h12345678;
    b = 32'h87654321;
    c = 32'h00010000;
    pipe.issue(cmd(product_to_acc_op, 1'b1, a, b), 1'b0, st);
    acc_at(2, prod(1'b1, a, b));
    pipe.issue(cmd(product_to_acc_op, 1'b0, b, c), 1'b1, st);
    pipe.issue(cmd(product_to_acc_op, 1'b0, a, b), 1'b0, st);
    chk("long repeat stall", st, 1);
    acc_exp = prod(1'b0, b, c);
    acc_at(2, prod(1'b0, a, b));
  endtask
  task automatic t_acc();
    logic [31:0] a, b, c;
    a = 32'h89ABCDEF;
    b = 32'h00001234;
    c = 32'h40000001;
    for (int s = 0; s < 2; s++) begin
      pipe.issue(cmd(product_to_acc_op, s[0], a, b), 1'b0, st);
      acc_at(1, prod(s[0], a, b));
      pipe.issue(cmd(acc_plus_product_op, s[0], a, b), 1'b0, st);
      acc_at(1, acc_exp + prod(s[0], a, b));
      pipe.issue(cmd(acc_minus_product_op, s[0], a, c), 1'b0, st);
      acc_at(2, acc_exp - prod(s[0], a, c));
    end
  endtask
  task automatic t_gpr();
    pipe.issue(cmd(product_to_gpr_op, 1'b1, 32'hFFFFFFFD, 32'h100), 1'b0, st);
    gpr_at(2, 32'hFFFFFD00);
    pipe.issue(cmd(product_to_gpr_op, 1'b0, 32'h10001, 32'h30000), 1'b0, st);
    gpr_at(3, 32'h00030000);
    chk("acc kept", acc(), acc_exp);
    pipe.issue(cmd(move_from_top_op, 1'b0, 32'h0, 32'h0), 1'b0, st);
    chk("top moved", {gpr_valid, gpr_data}, {1'b1, acc_exp[63:32]});
    pipe.issue(cmd(move_from_bottom_op, 1'b0, 32'h0, 32'h0), 1'b0, st);
    chk("low moved", {gpr_valid, gpr_data}, {1'b1, acc_exp[31:0]});
  endtask
  task automatic t_div();
    logic [31:0] dv [5];
    int lat [5];
    logic sg [5];
    logic [31:0] q, r;
    dv = '{32'hFFFFFF9C, 32'h3E8, 32'h186A0, 32'h12345678, 32'hC8};
    lat = '{12, 19, 26, 33, 12};
    sg = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 5; k++) begin
      if (sg[k]) begin
        q = $signed(dv[k]) / 32'sd7;
        r = $signed(dv[k]) % 32'sd7;
      end else begin
        q = dv[k] / 32'd7;
        r = dv[k] % 32'd7;
      end
      pipe.issue(cmd(quotient_op, sg[k], dv[k], 32'h7), 1'b0, st);
      chk("div busy", div_busy, 1'b1);
      repeat (lat[k] - 2) @(negedge clock);
      chk("div busy end", div_busy, 1'b1);
      chk("div early", acc(), acc_exp);
      @(negedge clock);
      chk("div busy clear", div_busy, 1'b0);
      acc_exp = {r, q};
      chk("div result", acc(), acc_exp);
    end
    pipe.issue(cmd(quotient_op, 1'b1, 32'h64, 32'h3), 1'b1, st);
    pipe.issue(cmd(move_from_bottom_op, 1'b0, 32'h0, 32'h0), 1'b0, st);
    chk("div stall", st, 11);
    chk("moved quotient", {gpr_valid, gpr_data}, {1'b1, 32'h21});
  endtask
  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    err_total = 0;
    checks = 0;
    st = 0;
    acc_exp = 64'h0;
    sys_rst = 1'b1;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    t_reset();
    t_short();
    t_long();
    t_acc();
    t_gpr();
    t_div();
    wrap_up();
  end
  // the whole run needs well under 500 cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
